// [design/mecw_config_word.sv]
`timescale 1ns/100ps
module mecw_config_word #(
  parameter int VOLT_W = 32
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  input  wire logic              pass_start_in,
  input  wire logic              sample_valid_in,
  input  wire logic [VOLT_W-1:0] volt_mag_a_in,
  input  wire logic [VOLT_W-1:0] volt_mag_b_in,
  input  wire logic [VOLT_W-1:0] volt_mag_c_in,
  input  wire logic              square_a_in,
  input  wire logic              square_b_in,
  input  wire logic              square_c_in,
  input  wire logic [15:0]       die_temp_in,
  input  wire logic [31:0]       total_watt_sum_in,
  input  wire logic [31:0]       total_var_sum_in,
  output logic      [31:0]       real_pulse_gen_input_out,
  output logic      [31:0]       reactive_pulse_gen_input_out,
  output logic      [VOLT_W-1:0] pll_ref_voltage_out,
  output logic      [1:0]        ref_phase_out,
  output logic      [1:0]        lag_first_phase_out,
  output logic      [1:0]        lag_second_phase_out,
  output logic                   fundamental_square_wave_out,
  output logic      [2:0]        x8_gain_out,
  output logic      [15:0]       global_gain_scale_out,
  output logic      [2:0]        sag_flags_out,
  output logic                   reactive_pulse_pin_out,
  output logic                   irq_out
);

  generate
    if (VOLT_W < 1 || VOLT_W > 32) begin : g_bad_width
      $error("VOLT_W must lie between 1 and 32.");
    end
  endgenerate

  typedef struct packed {
    logic [31:0]           cfg_sw;
    logic [31:0]           cfg_act;
    logic [15:0]           gain;
    logic [15:0]           lin;
    logic [15:0]           quad;
    logic [15:0]           tnom;
    logic [31:0]           host_real;
    logic [31:0]           host_react;
    logic [VOLT_W-1:0]     thr;
    logic [2:0][7:0]       sag_sample_count;
    logic [2:0]            sag_flag;
    logic                  qual_d;
    logic                  pin;
    logic [1:0]            irq_stat;
    logic [1:0]            irq_mask;
    logic                  irq;
    logic                  ack;
    logic [31:0]           rdat;
    logic [31:0]           real_out;
    logic [31:0]           react_out;
    logic [VOLT_W-1:0]     pll_v;
    logic [1:0]            ref_sel;
    logic [1:0]            lag1;
    logic [1:0]            lag2;
    logic                  square;
    logic                  square_d;
    logic [31:0]           half_cycles;
    logic [2:0]            x8;
  } mecw_state_s;

  mecw_state_s st_reg;
  mecw_state_s st_next;

  logic [VOLT_W-1:0]  vmag [3];
  logic [2:0]         below;
  logic [2:0]         above;
  logic [2:0]         sag_en;
  logic               qual_now;
  logic [1:0]         sel_act;
  logic signed [15:0] dt;
  logic signed [31:0] lin_p;
  logic signed [47:0] quad_p;
  logic signed [47:0] gsum;
  logic [15:0]        gain_calc;
  logic               wr_fire;
  logic [31:0]        wmask;
  logic [7:0]         cnt_inc;
  logic [31:0]        rd_mux;

  assign vmag[0] = volt_mag_a_in;
  assign vmag[1] = volt_mag_b_in;
  assign vmag[2] = volt_mag_c_in;
  assign sag_en  = st_reg.cfg_act[mecw_pkg::BIT_SAG_EN_LO +: 3];
  assign sel_act = st_reg.cfg_act[mecw_pkg::BIT_PHASE_LO +: 2];
  assign wr_fire = st_reg.ack & wb_cyc_in & wb_stb_in & wb_we_in;
  assign wmask   = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  // The sag event is only raised when every enabled phase sags at once.
  assign qual_now = (sag_en != 3'b000) && ((st_reg.sag_flag & sag_en) == sag_en);

  // Temperature compensation polynomial around the calibration temperature.
  assign dt        = $signed(die_temp_in) - $signed(st_reg.tnom);
  assign lin_p     = $signed(st_reg.lin) * dt;
  assign quad_p    = $signed({{32{st_reg.quad[15]}}, st_reg.quad}) * $signed({{32{dt[15]}}, dt}) * dt;
  assign gsum      = $signed({32'h0000_0000, mecw_pkg::GAIN_UNITY}) + ({{16{lin_p[31]}}, lin_p} >>> mecw_pkg::LIN_SHIFT)
                     + (quad_p >>> mecw_pkg::QUAD_SHIFT);
  assign gain_calc = gsum[15:0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_in)
      mecw_pkg::OFS_CONFIG:      rd_mux = st_reg.cfg_sw;
      mecw_pkg::OFS_STATUS: begin
        rd_mux[mecw_pkg::BIT_STAT_SQUARE]       = st_reg.square;
        rd_mux[mecw_pkg::BIT_STAT_SAG_LO +: 3] = st_reg.sag_flag;
      end
      mecw_pkg::OFS_IRQ_STATUS:  rd_mux[1:0] = st_reg.irq_stat;
      mecw_pkg::OFS_IRQ_MASK:    rd_mux[1:0] = st_reg.irq_mask;
      mecw_pkg::OFS_GAIN:        rd_mux[15:0] = st_reg.gain;
      mecw_pkg::OFS_LIN_COEFF:   rd_mux[15:0] = st_reg.lin;
      mecw_pkg::OFS_QUAD_COEFF:  rd_mux[15:0] = st_reg.quad;
      mecw_pkg::OFS_CAL_TEMP:    rd_mux[15:0] = st_reg.tnom;
      mecw_pkg::OFS_HOST_REAL:   rd_mux = st_reg.host_real;
      mecw_pkg::OFS_HOST_REACT:  rd_mux = st_reg.host_react;
      mecw_pkg::OFS_SAG_LEVEL:   rd_mux[VOLT_W-1:0] = st_reg.thr;
      mecw_pkg::OFS_HALF_CYCLES: rd_mux = st_reg.half_cycles;
      default:                   rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    cnt_inc = 8'h00;
    below   = 3'b000;
    above   = 3'b000;

    // Bus slave: one-cycle ack, writes land on the edge where the master sees ack.
    st_next.ack = wb_cyc_in & wb_stb_in & ~st_reg.ack;
    if (wb_cyc_in & wb_stb_in & ~st_reg.ack) begin
      st_next.rdat = rd_mux;
    end
    if (wr_fire) begin
      case (wb_adr_in)
        mecw_pkg::OFS_CONFIG:
          st_next.cfg_sw = ((st_reg.cfg_sw & ~wmask) | (wb_dat_in & wmask)) & mecw_pkg::CFG_WRITE_MASK;
        mecw_pkg::OFS_IRQ_MASK:    st_next.irq_mask = wb_sel_in[0] ? wb_dat_in[1:0] : st_reg.irq_mask;
        mecw_pkg::OFS_GAIN: begin
          if (st_reg.cfg_act[mecw_pkg::BIT_TEMP_OWNER]) begin
            st_next.gain = (st_reg.gain & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
          end
        end
        mecw_pkg::OFS_LIN_COEFF:   st_next.lin  = (st_reg.lin & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
        mecw_pkg::OFS_QUAD_COEFF:  st_next.quad = (st_reg.quad & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
        mecw_pkg::OFS_CAL_TEMP:    st_next.tnom = (st_reg.tnom & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
        mecw_pkg::OFS_HOST_REAL:   st_next.host_real  = (st_reg.host_real & ~wmask) | (wb_dat_in & wmask);
        mecw_pkg::OFS_HOST_REACT:  st_next.host_react = (st_reg.host_react & ~wmask) | (wb_dat_in & wmask);
        mecw_pkg::OFS_SAG_LEVEL:
          st_next.thr = (st_reg.thr & ~wmask[VOLT_W-1:0]) | (wb_dat_in[VOLT_W-1:0] & wmask[VOLT_W-1:0]);
        default: begin
        end
      endcase
    end

    // The working copy only changes between passes, so a pass never sees a half-written word.
    if (pass_start_in) begin
      st_next.cfg_act = st_reg.cfg_sw;
      if (!st_reg.cfg_act[mecw_pkg::BIT_TEMP_OWNER]) begin
        st_next.gain = gain_calc;
      end
    end

    // Per-phase sag detection on each voltage sample.
    for (int i = 0; i < 3; i++) begin
      below[i] = sample_valid_in && (vmag[i] < st_reg.thr);
      above[i] = sample_valid_in && (vmag[i] > st_reg.thr);
      cnt_inc  = (st_reg.sag_sample_count[i] == 8'hFF) ? 8'hFF : st_reg.sag_sample_count[i] + 8'h01;
      if (below[i]) begin
        st_next.sag_sample_count[i] = cnt_inc;
        if (cnt_inc >= st_reg.cfg_act[mecw_pkg::BIT_SAG_NUM_LO +: 8]) begin
          st_next.sag_flag[i] = 1'b1;
        end
      end else if (sample_valid_in) begin
        st_next.sag_sample_count[i] = 8'h00;
        if (above[i]) begin
          st_next.sag_flag[i] = 1'b0;
        end
      end
    end

    st_next.qual_d = qual_now;
    if (qual_now && !st_reg.qual_d && st_reg.cfg_act[mecw_pkg::BIT_SAG_ROUTE]) begin
      st_next.pin = ~st_reg.pin;
    end

    // Sticky events: a new event wins over a write-one-to-clear in the same cycle.
    if (wr_fire && wb_adr_in == mecw_pkg::OFS_IRQ_STATUS && wb_sel_in[0]) begin
      st_next.irq_stat = st_reg.irq_stat & ~wb_dat_in[1:0];
    end
    if (qual_now && !st_reg.qual_d) begin
      st_next.irq_stat[mecw_pkg::IRQ_SAG] = 1'b1;
    end
    if (pass_start_in) begin
      st_next.irq_stat[mecw_pkg::IRQ_PASS] = 1'b1;
    end
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // Reference phase routing; the forbidden code falls back to phase A.
    case (sel_act)
      mecw_pkg::PHASE_B: begin
        st_next.lag1   = mecw_pkg::PHASE_C;
        st_next.lag2   = mecw_pkg::PHASE_A;
        st_next.square = square_b_in;
        st_next.pll_v  = volt_mag_b_in;
        st_next.ref_sel = mecw_pkg::PHASE_B;
      end
      mecw_pkg::PHASE_C: begin
        st_next.lag1   = mecw_pkg::PHASE_A;
        st_next.lag2   = mecw_pkg::PHASE_B;
        st_next.square = square_c_in;
        st_next.pll_v  = volt_mag_c_in;
        st_next.ref_sel = mecw_pkg::PHASE_C;
      end
      default: begin
        st_next.lag1   = mecw_pkg::PHASE_B;
        st_next.lag2   = mecw_pkg::PHASE_C;
        st_next.square = square_a_in;
        st_next.pll_v  = volt_mag_a_in;
        st_next.ref_sel = mecw_pkg::PHASE_A;
      end
    endcase
    st_next.square_d = st_reg.square;
    if (st_reg.square != st_reg.square_d) begin
      st_next.half_cycles = st_reg.half_cycles + 32'h0000_0001;
    end

    if (st_reg.cfg_act[mecw_pkg::BIT_PULSE_SRC]) begin
      st_next.real_out  = st_reg.host_real;
      st_next.react_out = st_reg.host_react;
    end else begin
      st_next.real_out  = total_watt_sum_in;
      st_next.react_out = total_var_sum_in;
    end

    st_next.x8 = st_reg.cfg_act[mecw_pkg::BIT_X8_LO +: 3];
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg            <= '0;
      st_reg.cfg_sw     <= mecw_pkg::CFG_RESET;
      st_reg.cfg_act    <= mecw_pkg::CFG_RESET;
      st_reg.gain       <= mecw_pkg::GAIN_UNITY;
      st_reg.thr        <= mecw_pkg::SAG_LEVEL_RESET[VOLT_W-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_out                   = st_reg.rdat;
  assign wb_ack_out                   = st_reg.ack;
  assign real_pulse_gen_input_out     = st_reg.real_out;
  assign reactive_pulse_gen_input_out = st_reg.react_out;
  assign pll_ref_voltage_out          = st_reg.pll_v;
  assign ref_phase_out                = st_reg.ref_sel;
  assign lag_first_phase_out          = st_reg.lag1;
  assign lag_second_phase_out         = st_reg.lag2;
  assign fundamental_square_wave_out  = st_reg.square;
  assign x8_gain_out                  = st_reg.x8;
  assign global_gain_scale_out        = st_reg.gain;
  assign sag_flags_out                = st_reg.sag_flag;
  assign reactive_pulse_pin_out       = st_reg.pin;
  assign irq_out                      = st_reg.irq;

  a_sag_irq_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (qual_now && !st_reg.qual_d) |=> st_reg.irq_stat[mecw_pkg::IRQ_SAG])
    else $error("Sag event did not set its status bit.");

  a_sag_no_enable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sag_en == 3'b000) |=> !st_reg.irq_stat[mecw_pkg::IRQ_SAG] || $past(st_reg.irq_stat[mecw_pkg::IRQ_SAG]))
    else $error("Sag status set with no phase enabled.");

  a_pin_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (qual_now && !st_reg.qual_d && st_reg.cfg_act[mecw_pkg::BIT_SAG_ROUTE]) |=> $changed(st_reg.pin))
    else $error("Routed sag event did not toggle the pin.");

  a_pin_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !st_reg.cfg_act[mecw_pkg::BIT_SAG_ROUTE] |=> $stable(st_reg.pin))
    else $error("Pulse pin moved while sag routing is off.");

  a_gain_engine: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (pass_start_in && !st_reg.cfg_act[mecw_pkg::BIT_TEMP_OWNER]) |=> (st_reg.gain == $past(gain_calc)))
    else $error("Engine did not load the compensated gain.");

  a_gain_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_reg.cfg_act[mecw_pkg::BIT_TEMP_OWNER] && !wr_fire) |=> $stable(st_reg.gain))
    else $error("Gain changed while the controller owns it.");

  a_sag_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    above[0] |=> !st_reg.sag_flag[0])
    else $error("Sag flag A stayed set above threshold.");

  a_sag_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_reg.sag_flag[1] && !above[1]) |=> st_reg.sag_flag[1])
    else $error("Sag flag B dropped without recovery.");

  a_sag_declare: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (below[0] && st_reg.sag_sample_count[0] == 8'h00 && st_reg.cfg_act[mecw_pkg::BIT_SAG_NUM_LO +: 8] > 8'h01)
      |=> !$rose(st_reg.sag_flag[0]))
    else $error("Sag flag A set after a single low sample.");

  a_cfg_pass: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !pass_start_in |=> $stable(st_reg.cfg_act))
    else $error("Working configuration changed inside a pass.");

  a_pulse_src: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !st_reg.cfg_act[mecw_pkg::BIT_PULSE_SRC] |=> (st_reg.real_out == $past(total_watt_sum_in)))
    else $error("Real pulse input not taken from the watt sum.");

  a_lag_pairs: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sel_act == mecw_pkg::PHASE_B) |=> (st_reg.lag1 == mecw_pkg::PHASE_C && st_reg.lag2 == mecw_pkg::PHASE_A))
    else $error("Wrong lag pair for phase B.");

  a_pll_source: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sel_act == mecw_pkg::PHASE_C) |=> (st_reg.pll_v == $past(volt_mag_c_in)))
    else $error("PLL not fed from phase C.");

  a_shunt_gain: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    1'b1 |=> (st_reg.x8 == $past(st_reg.cfg_act[mecw_pkg::BIT_X8_LO +: 3])))
    else $error("Shunt gain bits do not follow the configuration.");

  a_sticky_sag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_reg.irq_stat[mecw_pkg::IRQ_SAG] && !(wr_fire && wb_adr_in == mecw_pkg::OFS_IRQ_STATUS && wb_sel_in[0]))
      |=> st_reg.irq_stat[mecw_pkg::IRQ_SAG])
    else $error("Sag status bit dropped without a clear.");

  a_gain_refuse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_fire && wb_adr_in == mecw_pkg::OFS_GAIN && !st_reg.cfg_act[mecw_pkg::BIT_TEMP_OWNER] && !pass_start_in)
      |=> $stable(st_reg.gain))
    else $error("Gain took a controller write while the engine owns it.");

  a_lag_pairs_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sel_act == mecw_pkg::PHASE_A) |=> (st_reg.lag1 == mecw_pkg::PHASE_B && st_reg.lag2 == mecw_pkg::PHASE_C))
    else $error("Wrong lag pair for phase A.");

endmodule

// [design/mecw_pkg.sv]
// Behaviour
// - Per-phase sag enable bits, reset zero.
// - Several enables: sag only when all sag.
// - Routed sag event toggles reactive pulse pin.
// - Owner zero: engine computes global gain scale.
// - Owner one: engine stops, controller writes gain.
// - Sag count field sets consecutive samples needed.
// - Sag flag holds until voltage exceeds threshold.
// - Phase select codes A, B, C; never 11.
// - Selected phase drives monitors and lag pairs.
// - Selected phase voltage feeds the PLL.
// - Pulse source bit picks engine or controller.
// - Shunt bits multiply channel gain by eight.
package mecw_pkg;

  localparam logic [7:0]  OFS_CONFIG      = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  OFS_GAIN        = 8'h10;
  localparam logic [7:0]  OFS_LIN_COEFF   = 8'h14;
  localparam logic [7:0]  OFS_QUAD_COEFF  = 8'h18;
  localparam logic [7:0]  OFS_CAL_TEMP    = 8'h1C;
  localparam logic [7:0]  OFS_HOST_REAL   = 8'h20;
  localparam logic [7:0]  OFS_HOST_REACT  = 8'h24;
  localparam logic [7:0]  OFS_SAG_LEVEL   = 8'h28;
  localparam logic [7:0]  OFS_HALF_CYCLES = 8'h2C;

  localparam logic [31:0] CFG_RESET       = 32'h0000_5020;
  localparam logic [31:0] CFG_WRITE_MASK  = 32'h001F_FFFF;
  localparam int          BIT_SAG_EN_LO   = 18;
  localparam int          BIT_SAG_ROUTE   = 17;
  localparam int          BIT_TEMP_OWNER  = 16;
  localparam int          BIT_SAG_NUM_LO  = 8;
  localparam int          BIT_PHASE_LO    = 6;
  localparam int          BIT_PULSE_SRC   = 5;
  localparam int          BIT_X8_LO       = 2;

  localparam int          BIT_STAT_SAG_LO = 25;
  localparam int          BIT_STAT_SQUARE = 28;

  localparam logic [1:0]  PHASE_A         = 2'b00;
  localparam logic [1:0]  PHASE_B         = 2'b01;
  localparam logic [1:0]  PHASE_C         = 2'b10;

  localparam int          IRQ_SAG         = 0;
  localparam int          IRQ_PASS        = 1;

  localparam logic [15:0] GAIN_UNITY      = 16'h4000;
  localparam logic [31:0] SAG_LEVEL_RESET = 32'h0000_0000;
  localparam int          LIN_SHIFT       = 14;
  localparam int          QUAD_SHIFT      = 22;

endpackage

// [tb/mecw_engine_feed.sv]
`timescale 1ns/100ps
module mecw_engine_feed (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       run_in,
  output logic            pass_start_out,
  output logic            sample_valid_out,
  output logic      [2:0] square_out
);
  logic [7:0] cnt_reg;

  // A start pulse comes every eighth cycle while running, so passes never overlap.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_reg          <= 8'h00;
      pass_start_out   <= 1'b0;
      sample_valid_out <= 1'b0;
      square_out       <= 3'b000;
    end else begin
      cnt_reg          <= cnt_reg + 8'h01;
      pass_start_out   <= run_in && (cnt_reg[2:0] == 3'h7);
      sample_valid_out <= cnt_reg[0];
      square_out       <= {cnt_reg[7], cnt_reg[6], cnt_reg[5]};
    end
  end
endmodule

// [tb/metering_engine_config_word_bench.sv]
`timescale 1ns/100ps
module metering_engine_config_word_bench;
  logic        clk_in     = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        cyc        = 1'b0;
  logic        stb        = 1'b0;
  logic        we         = 1'b0;
  logic [7:0]  adr        = 8'h00;
  logic [3:0]  sel        = 4'h0;
  logic [31:0] dat        = 32'h0000_0000;
  logic        run        = 1'b0;
  logic [15:0] die_temp   = 16'h0040;
  logic [31:0] watt       = 32'h1234_5678;
  logic [31:0] vsum       = 32'h0ABC_DEF0;
  logic [31:0] volt [3];
  logic [31:0] rd, dat_o, rp, xp, pll, hc;
  logic [15:0] gain;
  logic [2:0]  x8, flags, sq, sq_d;
  logic [1:0]  ref_ph, lag1, lag2;
  logic        ack, fsq, pin, pin0, irq, pass, smp;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          prev;

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) sq_d <= sq;

  mecw_engine_feed mecw_engine_feed_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .run_in(run),
    .pass_start_out(pass), .sample_valid_out(smp), .square_out(sq));

  mecw_config_word mecw_config_word_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .wb_dat_out(dat_o), .wb_ack_out(ack), .pass_start_in(pass), .sample_valid_in(smp),
    .volt_mag_a_in(volt[0]), .volt_mag_b_in(volt[1]), .volt_mag_c_in(volt[2]),
    .square_a_in(sq[0]), .square_b_in(sq[1]), .square_c_in(sq[2]), .die_temp_in(die_temp),
    .total_watt_sum_in(watt), .total_var_sum_in(vsum), .real_pulse_gen_input_out(rp),
    .reactive_pulse_gen_input_out(xp), .pll_ref_voltage_out(pll), .ref_phase_out(ref_ph),
    .lag_first_phase_out(lag1), .lag_second_phase_out(lag2), .fundamental_square_wave_out(fsq),
    .x8_gain_out(x8), .global_gain_scale_out(gain), .sag_flags_out(flags),
    .reactive_pulse_pin_out(pin), .irq_out(irq));

  task automatic end_sim;
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) num_errors++;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Lets exactly one pass start through, then waits for the registered outputs.
  task automatic pass_go;
    int n;
    @(posedge clk_in);
    run <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pass !== 1'b1 && n < 40);
    run <= 1'b0;
    if (n >= 40) num_errors++;
    settle(2);
  endtask

  initial begin
    #200_000;
    num_errors++;
    end_sim();
  end

  initial begin
    volt[0] = 32'h0000_07D0;
    volt[1] = 32'h0000_0BB8;
    volt[2] = 32'h0000_0FA0;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wb(0, mecw_pkg::OFS_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_5020);
    chk({16'h0000, gain}, 32'h0000_4000);
    chk({29'h0000_0000, x8}, 32'h0000_0000);
    chk({29'h0000_0000, flags}, 32'h0000_0000);
    wb(0, 8'hFC, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    prev = 0;
    for (int i = 0; i < 3; i++) begin
      int p;
      p = (i + 1) % 3;
      wb(1, mecw_pkg::OFS_CONFIG, {24'h00_0000, 2'(p), 1'b0, 3'(1 << p), 2'b00});
      settle(3);
      chk(32'(ref_ph), 32'(prev));
      pass_go();
      chk(32'(ref_ph), 32'(p));
      chk(32'(lag1), 32'((p + 1) % 3));
      chk(32'(lag2), 32'((p + 2) % 3));
      chk(32'(fsq), 32'(sq_d[p]));
      chk(pll, volt[p]);
      chk(32'(x8), 32'(1 << p));
      chk(rp, watt);
      chk(xp, vsum);
      prev = p;
    end
    wb(1, mecw_pkg::OFS_HOST_REAL, 32'h1111_2222);
    wb(1, mecw_pkg::OFS_HOST_REACT, 32'h3333_4444);
    wb(1, mecw_pkg::OFS_CONFIG, 32'h0000_0020);
    pass_go();
    chk(rp, 32'h1111_2222);
    chk(xp, 32'h3333_4444);
    wb(1, mecw_pkg::OFS_SAG_LEVEL, 32'h0000_03E8);
    wb(1, mecw_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wb(1, mecw_pkg::OFS_CONFIG, 32'h000E_0300);
    pass_go();
    pin0 = pin;
    volt[0] <= 32'h0000_01F4;
    settle(12);
    chk({29'h0000_0000, flags}, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    volt[1] <= 32'h0000_01F4;
    settle(12);
    chk({29'h0000_0000, flags}, 32'h0000_0003);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    chk({31'h0000_0000, pin}, {31'h0000_0000, ~pin0});
    wb(0, mecw_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0E00_0000, 32'h0600_0000);
    wb(1, mecw_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    settle(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wb(1, mecw_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    volt[0] <= 32'h0000_03E8;
    settle(12);
    chk({29'h0000_0000, flags}, 32'h0000_0003);
    volt[0] <= 32'h0000_07D0;
    volt[1] <= 32'h0000_0BB8;
    settle(12);
    chk({29'h0000_0000, flags}, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wb(1, mecw_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    settle(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wb(1, mecw_pkg::OFS_LIN_COEFF, 32'h0000_0100);
    wb(1, mecw_pkg::OFS_QUAD_COEFF, 32'h0000_0000);
    wb(1, mecw_pkg::OFS_CAL_TEMP, 32'h0000_0000);
    wb(1, mecw_pkg::OFS_CONFIG, 32'h0000_0000);
    pass_go();
    chk({16'h0000, gain}, 32'h0000_4001);
    wb(1, mecw_pkg::OFS_GAIN, 32'h0000_1234);
    wb(0, mecw_pkg::OFS_GAIN, 32'h0000_0000);
    chk(rd, 32'h0000_4001);
    wb(1, mecw_pkg::OFS_CONFIG, 32'h0001_0000);
    pass_go();
    wb(1, mecw_pkg::OFS_GAIN, 32'h0000_1234);
    die_temp <= 16'h0080;
    pass_go();
    chk({16'h0000, gain}, 32'h0000_1234);
    wb(0, mecw_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    wb(0, mecw_pkg::OFS_HALF_CYCLES, 32'h0000_0000);
    hc = rd;
    settle(61);
    wb(0, mecw_pkg::OFS_HALF_CYCLES, 32'h0000_0000);
    chk(rd - hc, 32'h0000_0002);
    end_sim();
  end
endmodule
